// file: design/async_serial_control_regs.sv
// The AXI4-Lite slave port and the address map are this design's own decisions.
`default_nettype none
module async_serial_control_regs #(
    parameter int BIT_CYCLES = serial_ctrl_pkg::BIT_CYCLES
) (
    input  wire logic        mclk,
    input  wire logic        reset_n,
    input  wire logic [3:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [3:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    input  wire logic [7:0]  tx_data,
    input  wire logic        tx_data_write,
    input  wire logic [8:0]  rx_char,
    input  wire logic        rx_char_load,
    input  wire logic        rx_full_flag,
    input  wire logic        rx_idle_flag,
    input  wire logic        overrun_flag,
    input  wire logic        noise_error_flag,
    input  wire logic        framing_fault_flag,
    input  wire logic        parity_fault_flag,
    input  wire logic        serial_in,
    output logic             serial_out,
    output logic             rx_enable,
    output logic             tx_irq,
    output logic             rx_irq,
    output logic             err_irq,
    output logic             rx_parity_bad
);
    logic [7:0]  frame_reg;
    logic [7:0]  en_reg;
    logic [5:0]  err_ie;
    logic        tx_ninth_bit;
    logic        rx_ninth_bit;
    logic        tx_empty_flag;
    logic        tx_done_flag;
    logic        aw_held, w_held;
    logic [3:0]  aw_addr;
    logic [31:0] w_data;
    logic        w_strb0;
    logic        do_write;
    logic        rx_s1, rx_s2;
    logic [15:0] baud_cnt;
    logic        bit_tick;
    serial_ctrl_pkg::tx_state_t tx_state;
    logic [10:0] shifter;
    logic [3:0]  bits_left;
    logic        pend_pre, pend_brk, pend_idle, buf_full;
    logic [7:0]  tx_buf;
    logic [3:0]  idle_cnt;
    logic        tx_line;
    logic        wake_hit;
    logic        write_tx_rise, write_tx_reon, write_brk_set;
    logic        load_now, busy;

    wire module_on  = frame_reg[serial_ctrl_pkg::FF_MODULE_ON];
    wire nine_bit   = frame_reg[serial_ctrl_pkg::FF_CHAR_LEN];
    wire par_on     = frame_reg[serial_ctrl_pkg::FF_PARITY_ON];
    wire par_odd    = frame_reg[serial_ctrl_pkg::FF_PARITY_ODD];
    wire tx_on      = en_reg[serial_ctrl_pkg::EN_TX_ON];
    wire brk_on     = en_reg[serial_ctrl_pkg::EN_BREAK];
    wire [3:0] frame_bits = nine_bit ? serial_ctrl_pkg::FRAME_BITS_9
                                     : serial_ctrl_pkg::FRAME_BITS_8;

    // Write address and data may arrive in either order
    assign do_write = aw_held && w_held && !s_axi_bvalid;

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            aw_held <= 1'b0;
            aw_addr <= 4'h0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
        end else if (do_write) begin
            aw_held <= 1'b0;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            w_held  <= 1'b0;
            w_data  <= 32'h0;
            w_strb0 <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held  <= 1'b1;
            w_data  <= s_axi_wdata;
            w_strb0 <= s_axi_wstrb[0];
        end else if (do_write) begin
            w_held <= 1'b0;
        end
    end

    // Ready only while the holding slot is empty
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held && !(s_axi_awvalid && s_axi_awready);
            s_axi_wready  <= !w_held && !(s_axi_wvalid && s_axi_wready);
        end
    end

    // Write response; unmapped addresses answer SLVERR
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= serial_ctrl_pkg::RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr == serial_ctrl_pkg::ADDR_FLAGS ||
                             aw_addr[1:0] != 2'h0)
                            ? serial_ctrl_pkg::RESP_SLVERR
                            : serial_ctrl_pkg::RESP_OKAY;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control registers; tx/rx enables writable only with module on
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            frame_reg    <= serial_ctrl_pkg::RST_FRAME;
            en_reg       <= serial_ctrl_pkg::RST_ENABLE;
            err_ie       <= 6'h00;
            tx_ninth_bit <= 1'b0;
        end else begin
            if (do_write && w_strb0) begin
                case (aw_addr)
                    serial_ctrl_pkg::ADDR_FRAME: begin
                        frame_reg <= {1'b0, w_data[6:0]};
                    end
                    serial_ctrl_pkg::ADDR_ENABLE: begin
                        en_reg[7:4] <= w_data[7:4];
                        en_reg[1:0] <= w_data[1:0];
                        if (module_on) begin
                            en_reg[3:2] <= w_data[3:2];
                        end
                    end
                    serial_ctrl_pkg::ADDR_NINTH: begin
                        err_ie       <= {2'b00, w_data[3:0]};
                        tx_ninth_bit <= w_data[serial_ctrl_pkg::NB_TX_NINTH];
                    end
                    default: begin
                    end
                endcase
            end
            // Wake condition clears standby; it wins over a write
            if (en_reg[serial_ctrl_pkg::EN_STANDBY] && wake_hit) begin
                en_reg[serial_ctrl_pkg::EN_STANDBY] <= 1'b0;
            end
        end
    end

    // Read channel; one cycle from arvalid taken to rvalid
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= serial_ctrl_pkg::RESP_OKAY;
        end else if (s_axi_rvalid) begin
            s_axi_arready <= 1'b0;
            if (s_axi_rready) begin
                s_axi_rvalid  <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= serial_ctrl_pkg::RESP_OKAY;
            case (s_axi_araddr)
                serial_ctrl_pkg::ADDR_FRAME:  s_axi_rdata <= {24'h0, frame_reg};
                serial_ctrl_pkg::ADDR_ENABLE: s_axi_rdata <= {24'h0, en_reg};
                serial_ctrl_pkg::ADDR_NINTH:
                    s_axi_rdata <= {24'h0, rx_ninth_bit, tx_ninth_bit,
                                    err_ie};
                serial_ctrl_pkg::ADDR_FLAGS:
                    s_axi_rdata <= {24'h0, tx_empty_flag, tx_done_flag,
                                    rx_full_flag, rx_idle_flag,
                                    overrun_flag, noise_error_flag,
                                    framing_fault_flag, parity_fault_flag};
                default: begin
                    s_axi_rdata <= 32'h0;
                    s_axi_rresp <= serial_ctrl_pkg::RESP_SLVERR;
                end
            endcase
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // Two-stage synchroniser on the receive pin
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rx_s1 <= 1'b1;
            rx_s2 <= 1'b1;
        end else begin
            rx_s1 <= serial_in;
            rx_s2 <= rx_s1;
        end
    end

    // Bit-time enable; stops while the module is off
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            baud_cnt <= 16'h0;
            bit_tick <= 1'b0;
        end else if (!module_on) begin
            baud_cnt <= 16'h0;
            bit_tick <= 1'b0;
        end else if (baud_cnt == 16'(BIT_CYCLES - 1)) begin
            baud_cnt <= 16'h0;
            bit_tick <= 1'b1;
        end else begin
            baud_cnt <= baud_cnt + 16'h1;
            bit_tick <= 1'b0;
        end
    end

    // Idle detector: counts ones, restart point follows the select bit
    logic rx_prev;
    wire  idle_seen = (idle_cnt == frame_bits);
    wire  count_rst = frame_reg[serial_ctrl_pkg::FF_IDLE_START]
                      ? rx_char_load : (rx_prev && !rx_s2);
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            idle_cnt <= 4'h0;
            rx_prev  <= 1'b1;
        end else begin
            rx_prev <= rx_s2;
            if (count_rst || !rx_s2) begin
                idle_cnt <= 4'h0;
            end else if (bit_tick && !idle_seen) begin
                idle_cnt <= idle_cnt + 4'h1;
            end
        end
    end

    // Address mark is the top bit of the received character
    wire mark_bit = nine_bit ? rx_char[8] : rx_char[7];
    assign wake_hit = frame_reg[serial_ctrl_pkg::FF_STANDBY_EX]
                      ? (rx_char_load && mark_bit) : idle_seen;

    // Received mark bit (rx_char[8], or rx_char[7] in 8-bit mode); not reset, captured with the data buffer
    always_ff @(posedge mclk) begin
        if (rx_char_load) begin
            rx_ninth_bit <= mark_bit;
        end
    end

    // Parity check on received character
    wire [8:0] rx_mask = nine_bit ? 9'h1FF : 9'h0FF;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rx_parity_bad <= 1'b0;
        end else if (rx_char_load) begin
            rx_parity_bad <= par_on &&
                ((^(rx_char & rx_mask)) != par_odd);
        end
    end

    // Data buffer write from the host side
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tx_buf   <= 8'h0;
            buf_full <= 1'b0;
        end else if (tx_data_write) begin
            tx_buf   <= tx_data;
            buf_full <= 1'b1;
        end else if (load_now) begin
            // Same condition as the sequencer load, back to back too
            buf_full <= 1'b0;
        end
    end

    // Frame word: start, data with optional parity, ninth bit, stop
    logic [8:0] tx_payload;
    always_comb begin
        tx_payload = {tx_ninth_bit, tx_buf};
        if (par_on) begin
            if (nine_bit) begin
                tx_payload[8] = (^tx_buf) ^ par_odd;
            end else begin
                tx_payload[7] = (^tx_buf[6:0]) ^ par_odd;
            end
        end
        if (!nine_bit) begin
            tx_payload[8] = 1'b1;
        end
    end

    // Transmit sequencer: preamble, break, idle char or data
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tx_state  <= serial_ctrl_pkg::TX_IDLE;
            shifter   <= 11'h7FF;
            bits_left <= 4'h0;
            pend_pre  <= 1'b0;
            pend_brk  <= 1'b0;
            pend_idle <= 1'b0;
            tx_line   <= 1'b1;
        end else begin
            if (write_tx_rise) begin
                pend_pre <= 1'b1;
            end
            if (write_tx_reon && tx_state != serial_ctrl_pkg::TX_IDLE) begin
                pend_idle <= 1'b1;
            end
            // A break already under way counts as the one owed
            if (write_brk_set && tx_state != serial_ctrl_pkg::TX_BRK) begin
                pend_brk <= 1'b1;
            end
            if (bit_tick) begin
                if (tx_state != serial_ctrl_pkg::TX_IDLE &&
                    bits_left != 4'h0) begin
                    tx_line   <= shifter[0];
                    shifter   <= {1'b1, shifter[10:1]};
                    bits_left <= bits_left - 4'h1;
                end else if (pend_brk || brk_on) begin
                    // Break replaces a preamble not yet started
                    tx_state  <= serial_ctrl_pkg::TX_BRK;
                    shifter   <= 11'h000;
                    bits_left <= frame_bits;
                    pend_brk  <= 1'b0;
                    pend_pre  <= 1'b0;
                end else if (tx_on && (pend_pre || pend_idle)) begin
                    tx_state  <= serial_ctrl_pkg::TX_PRE;
                    tx_line   <= 1'b1;
                    shifter   <= 11'h7FF;
                    bits_left <= frame_bits;
                    pend_pre  <= 1'b0;
                    pend_idle <= 1'b0;
                end else if (tx_on && buf_full) begin
                    tx_state  <= serial_ctrl_pkg::TX_DATA;
                    tx_line   <= 1'b1; // one mark after a break
                    shifter   <= nine_bit ? {1'b1, tx_payload, 1'b0}
                                          : {2'b11, tx_payload[7:0], 1'b0};
                    bits_left <= frame_bits;
                end else begin
                    tx_state <= serial_ctrl_pkg::TX_IDLE;
                    tx_line  <= 1'b1;
                end
            end
        end
    end

    // Software edges on tx_on and break_send
    logic tx_on_d, brk_d, tx_off_seen;
    assign write_tx_rise = tx_on && !tx_on_d;
    assign write_tx_reon = write_tx_rise && tx_off_seen;
    assign write_brk_set = !brk_on && brk_d;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tx_on_d     <= 1'b0;
            brk_d       <= 1'b0;
            tx_off_seen <= 1'b0;
        end else begin
            tx_on_d <= tx_on;
            brk_d   <= brk_on;
            if (!tx_on && tx_on_d) begin
                tx_off_seen <= 1'b1;
            end else if (tx_state == serial_ctrl_pkg::TX_IDLE) begin
                tx_off_seen <= 1'b0;
            end
        end
    end

    // Empty and done flags; module off forces both set
    assign load_now = bit_tick && bits_left == 4'h0 && !pend_brk &&
                      !brk_on && tx_on && !pend_pre && !pend_idle &&
                      buf_full;
    assign busy = (tx_state != serial_ctrl_pkg::TX_IDLE) || pend_pre ||
                  pend_brk || pend_idle || brk_on || buf_full;
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tx_empty_flag <= 1'b1;
            tx_done_flag  <= 1'b1;
        end else if (!module_on) begin
            tx_empty_flag <= 1'b1;
            tx_done_flag  <= 1'b1;
        end else begin
            if (load_now) begin
                tx_empty_flag <= 1'b1;
            end else if (tx_data_write) begin
                tx_empty_flag <= 1'b0;
            end
            tx_done_flag <= tx_empty_flag && !busy;
        end
    end

    // Interrupt requests, each registered once
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            tx_irq  <= 1'b0;
            rx_irq  <= 1'b0;
            err_irq <= 1'b0;
        end else begin
            tx_irq <= module_on &&
                ((tx_empty_flag && en_reg[serial_ctrl_pkg::EN_TXEMPTY_IE]) ||
                 (tx_done_flag && en_reg[serial_ctrl_pkg::EN_TXDONE_IE]));
            rx_irq <= !en_reg[serial_ctrl_pkg::EN_STANDBY] &&
                ((rx_full_flag && en_reg[serial_ctrl_pkg::EN_RXFULL_IE]) ||
                 (rx_idle_flag && en_reg[serial_ctrl_pkg::EN_IDLE_IE]));
            err_irq <= |({overrun_flag, noise_error_flag, framing_fault_flag,
                          parity_fault_flag} & err_ie[3:0]);
        end
    end

    // Pin outputs; inversion covers idle, break, start and stop
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            serial_out <= 1'b1;
            rx_enable  <= 1'b0;
        end else begin
            serial_out <= tx_line ^ frame_reg[serial_ctrl_pkg::FF_TX_FLIP];
            rx_enable  <= module_on && en_reg[serial_ctrl_pkg::EN_RX_ON];
        end
    end
endmodule
`default_nettype wire

// file: design/serial_ctrl_pkg.sv
`default_nettype none
package serial_ctrl_pkg;
    // Register byte addresses
    localparam logic [3:0] ADDR_FRAME   = 4'h0;
    localparam logic [3:0] ADDR_ENABLE  = 4'h4;
    localparam logic [3:0] ADDR_NINTH   = 4'h8;
    localparam logic [3:0] ADDR_FLAGS   = 4'hC;
    // frame_format_control fields
    localparam int FF_PARITY_ODD  = 0;
    localparam int FF_PARITY_ON   = 1;
    localparam int FF_IDLE_START  = 2;
    localparam int FF_STANDBY_EX  = 3;
    localparam int FF_CHAR_LEN    = 4;
    localparam int FF_TX_FLIP     = 5;
    localparam int FF_MODULE_ON   = 6;
    // enable_and_irq_control fields
    localparam int EN_BREAK       = 0;
    localparam int EN_STANDBY     = 1;
    localparam int EN_RX_ON       = 2;
    localparam int EN_TX_ON       = 3;
    localparam int EN_IDLE_IE     = 4;
    localparam int EN_RXFULL_IE   = 5;
    localparam int EN_TXDONE_IE   = 6;
    localparam int EN_TXEMPTY_IE  = 7;
    // ninth_bit_and_error_irq_control fields
    localparam int NB_PARITY_IE   = 0;
    localparam int NB_FRAMING_IE  = 1;
    localparam int NB_NOISE_IE    = 2;
    localparam int NB_OVERRUN_IE  = 3;
    localparam int NB_TX_NINTH    = 6;
    localparam int NB_RX_NINTH    = 7;
    // Reset values
    localparam logic [7:0] RST_FRAME  = 8'h00;
    localparam logic [7:0] RST_ENABLE = 8'h00;
    // AXI responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // Timing: one bit time
    localparam int CLK_HZ  = 100_000_000;
    localparam int BAUD_HZ = 115_200;
    localparam int BIT_CYCLES = CLK_HZ / BAUD_HZ;
    // Bit counts per frame
    localparam logic [3:0] FRAME_BITS_8 = 4'hA;
    localparam logic [3:0] FRAME_BITS_9 = 4'hB;
    typedef enum logic [1:0] {TX_IDLE, TX_PRE, TX_BRK, TX_DATA} tx_state_t;
endpackage
`default_nettype wire

// file: tb/serial_ctrl_assertions.sv
`default_nettype none
module serial_ctrl_checker (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic rx_full_flag,
    input wire logic rx_idle_flag,
    input wire logic rx_irq,
    input wire logic serial_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);
    // Bus steps that the answer checks are built from
    sequence rd_taken;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence rd_done;
        s_axi_rvalid && s_axi_rready;
    endsequence
    sequence wr_done;
        s_axi_bvalid && s_axi_bready;
    endsequence
    chk_read_answer: assert property (rd_taken |=> s_axi_rvalid)
        else $error("read answer late");
    chk_read_stands: assert property
        (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
        else $error("read answer dropped early");
    chk_read_ends: assert property (rd_done |=> !s_axi_rvalid)
        else $error("read answer repeated");
    chk_write_stands: assert property
        (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("write answer dropped early");
    chk_write_ends: assert property (wr_done |=> !s_axi_bvalid)
        else $error("write answer repeated");
    chk_idle_mark: assert property ($rose(reset_n) |-> serial_out)
        else $error("line not at mark after reset");
    chk_ready_up: assert property ($rose(reset_n) |-> ##[0:2] s_axi_arready)
        else $error("read address never ready");
    chk_rx_irq_cause: assert property
        (!rx_full_flag && !rx_idle_flag |=> !rx_irq)
        else $error("receiver request without source");
endmodule
bind async_serial_control_regs serial_ctrl_checker chk_u (.*);
`default_nettype wire

// file: tb/far_serial_node.sv
`default_nettype none
module far_serial_node #(
    parameter int BITC = 4
) (
    input  wire logic       mclk,
    input  wire logic       serial_out,
    input  wire logic [3:0] nbits,
    output var logic        serial_in,
    output var logic [8:0]  word,
    output var int          got
);
    timeunit 1ns;
    timeprecision 1ps;
    // Nothing sent back, so the line rests at mark
    initial serial_in = 1'h1;
    // Sample each data cell at its middle after a start edge
    initial begin
        got = 0;
        word = 9'h000;
        forever begin
            @(negedge serial_out);
            word = 9'h000;
            repeat (BITC / 2) @(posedge mclk);
            for (int i = 0; i < nbits - 2; i++) begin
                repeat (BITC) @(posedge mclk);
                word[i] = serial_out;
            end
            repeat (BITC) @(posedge mclk);
            got++;
        end
    end
endmodule
`default_nettype wire

// file: tb/tb_top.sv
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int BITC = 4;
    logic mclk = 1'h0, reset_n = 1'h0, s_axi_awvalid = 1'h0;
    logic s_axi_wvalid = 1'h0, s_axi_bready = 1'h0, s_axi_arvalid = 1'h0;
    logic s_axi_rready = 1'h0, tx_data_write = 1'h0, rx_char_load = 1'h0;
    logic rx_full_flag = 1'h0, rx_idle_flag = 1'h0, overrun_flag = 1'h0;
    logic noise_error_flag = 1'h0, framing_fault_flag = 1'h0;
    logic parity_fault_flag = 1'h0;
    logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, nbits = 4'hA;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
    logic [7:0] tx_data = 8'h00;
    logic [8:0] rx_char = 9'h000, word;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
    logic s_axi_rvalid, serial_in, serial_out, rx_enable, tx_irq;
    logic rx_irq, err_irq, rx_parity_bad;
    int got, err_count = 0, samples_checked = 0;
    async_serial_control_regs #(.BIT_CYCLES(BITC)) dut (.*);
    far_serial_node #(.BITC(BITC)) far (.*);
    // Short bit time keeps every frame a few dozen cycles
    always #5 mclk = ~mclk;
    task automatic chk(string nm, logic [31:0] e, logic [31:0] s);
        samples_checked++;
        if (s !== e) begin
            err_count++;
            $display("BAD %s expected %h seen %h", nm, e, s);
        end
    endtask
    // One edge of a bounded wait; running out ends the run
    task automatic tick(inout int n);
        @(posedge mclk);
        n++;
        if (n > 300) begin
            err_count++;
            report_and_stop();
        end
    endtask
    task automatic wr(logic [3:0] a, logic [7:0] d, logic [1:0] r = 2'h0);
        int n;
        n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        do begin
            tick(n);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end while (s_axi_awvalid && !s_axi_awready
                   || s_axi_wvalid && !s_axi_wready);
        s_axi_bready <= 1'h1;
        do tick(n); while (s_axi_bvalid !== 1'h1);
        chk("bresp", {30'h0, r}, {30'h0, s_axi_bresp});
        s_axi_bready <= 1'h0;
    endtask
    task automatic rdc(string nm, logic [3:0] a, logic [7:0] e,
                       logic [7:0] m = 8'hFF);
        int n;
        n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do tick(n); while (s_axi_arready !== 1'h1);
        s_axi_arvalid <= 1'h0;
        s_axi_rready <= 1'h1;
        do tick(n); while (s_axi_rvalid !== 1'h1);
        chk(nm, {24'h0, e & m}, s_axi_rdata & {24'h0, m});
        chk({nm, " resp"}, 32'h0, {30'h0, s_axi_rresp});
        s_axi_rready <= 1'h0;
    endtask
    // Requests are registered, so let them settle first
    task automatic bit_is(string nm, ref logic s, input logic e);
        repeat (3) @(posedge mclk);
        chk(nm, {31'h0, e}, {31'h0, s});
    endtask
    task automatic send(logic [3:0] nb, logic [7:0] d, logic [8:0] e);
        int n, g;
        n = 0;
        g = got;
        nbits <= nb;
        tx_data <= d;
        tx_data_write <= 1'h1;
        tick(n);
        tx_data_write <= 1'h0;
        do tick(n); while (got == g);
        chk("frame", {23'h0, e}, {23'h0, word});
    endtask
    // One-cycle hand-off of a received character
    task automatic take_rx(logic [8:0] c);
        rx_char <= c;
        rx_char_load <= 1'h1;
        @(posedge mclk);
        rx_char_load <= 1'h0;
    endtask
    // Set then clear break: one all-zero frame, then mark again
    task automatic brk_once();
        int n, g;
        n = 0;
        g = got;
        wr(4'h4, 8'h09);
        wr(4'h4, 8'h08);
        do tick(n); while (got == g);
        chk("break", 32'h0, {23'h0, word});
        bit_is("after break", serial_out, 1'h1);
    endtask
    initial begin
        repeat (12) @(posedge mclk);
        reset_n <= 1'h1;
        repeat (2) @(posedge mclk);
        rdc("frame rst", 4'h0, 8'h00);
        rdc("enable rst", 4'h4, 8'h00);
        rdc("ninth rst", 4'h8, 8'h00, 8'h7F);
        rdc("flags rst", 4'hC, 8'hC0);
        wr(4'hC, 8'hFF, serial_ctrl_pkg::RESP_SLVERR);
        wr(4'h4, 8'h0C);
        rdc("gated", 4'h4, 8'h00);
        wr(4'h0, 8'h40);
        wr(4'h4, 8'h8C);
        rdc("enables", 4'h4, 8'h8C);
        bit_is("rx enable", rx_enable, 1'h1);
        bit_is("tx irq", tx_irq, 1'h1);
        wr(4'h0, 8'h00);
        bit_is("tx irq off", tx_irq, 1'h0);
        wr(4'h0, 8'h40);
        rx_full_flag <= 1'h1;
        wr(4'h4, 8'h2C);
        bit_is("full irq", rx_irq, 1'h1);
        rx_full_flag <= 1'h0;
        rx_idle_flag <= 1'h1;
        wr(4'h4, 8'h1C);
        bit_is("idle irq", rx_irq, 1'h1);
        wr(4'h4, 8'h2C);
        bit_is("idle masked", rx_irq, 1'h0);
        rx_idle_flag <= 1'h0;
        for (int i = 0; i < 4; i++) begin
            {overrun_flag, noise_error_flag, framing_fault_flag,
             parity_fault_flag} <= 4'(1 << i);
            wr(4'h8, 8'(1 << i));
            bit_is("err irq", err_irq, 1'h1);
            wr(4'h8, 8'h0F ^ 8'(1 << i));
            bit_is("err masked", err_irq, 1'h0);
        end
        wr(4'h0, 8'h58);
        rx_full_flag <= 1'h1;
        wr(4'h4, 8'h2E);
        bit_is("standby", rx_irq, 1'h0);
        take_rx(9'h100);
        rdc("rx ninth", 4'h8, 8'h80, 8'h80);
        rdc("woken", 4'h4, 8'h2C);
        bit_is("awake irq", rx_irq, 1'h1);
        wr(4'h0, 8'h42);
        wr(4'h4, 8'h08);
        take_rx(9'h107);
        bit_is("rx parity bad", rx_parity_bad, 1'h1);
        rdc("rx ninth 8", 4'h8, 8'h00, 8'h80);
        take_rx(9'h087);
        bit_is("rx parity ok", rx_parity_bad, 1'h0);
        send(4'hA, 8'h07, 9'h087);
        repeat (8) @(posedge mclk);
        wr(4'h0, 8'h43);
        send(4'hA, 8'h87, 9'h007);
        wr(4'h0, 8'h50);
        wr(4'h8, 8'h40);
        send(4'hB, 8'hA5, 9'h1A5);
        brk_once();
        wr(4'h0, 8'h60);
        bit_is("flipped idle", serial_out, 1'h0);
        report_and_stop();
    end
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
endmodule
`default_nettype wire
